//--- hdl/iac_status_top.sv
/*
  Abort-cause recorder, receive-FIFO level counter and data-line hold
  register of a two-wire bus controller, with an AXI4-Lite register slave
  and a level interrupt.
  Assumes the master/slave state machines and FIFOs elsewhere in the
  controller drive the event inputs on mclk; the bus lines arrive raw from
  the pads and are resynchronised here.
*/

// Notes on behaviour
// - Receive level counts valid entries, tracking each push below RX_DEPTH and each pop above zero.
// - Read/write bit one written while answering a slave read sets bit 15.
// - Slave losing bus while transmitting sets bits 14 and 12 together.
// - Data line checked at each clock-line rise while master or slave transmits, against the driven bit.
// - Slave read command with stale transmit data sets bit 13, flushes FIFO.
// - Master losing arbitration sets bit 12.
// - Master and slave abort causes are recorded concurrently; bit 12 is shared, set by both master and slave bus loss.
// - Master start while master mode disabled sets bit 11.
// - Ten-bit read with repeated start disabled sets bit 10.
// - Start byte with repeated start disabled sets bit 9.
// - Bit 9 re-asserts after clearing unless its cause was removed.
// - High-speed transfer with repeated start disabled sets bit 8.
// - Acknowledged start byte sets bit 7.
// - Acknowledged high-speed master code sets bit 6.
// - Data byte not acknowledged after acknowledged address sets bit 3.
// - Seven-bit address not acknowledged sets bit 0.
module iac_status_top #(
  parameter int unsigned RX_DEPTH = 32
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   sclIn,
  input  wire logic                   sdaIn,
  input  wire logic                   rxPush,
  input  wire logic                   rxPop,
  input  wire logic                   slaveReadReq,
  input  wire logic                   dataCmdWrite,
  input  wire logic                   dataCmdReadBit,
  input  wire logic                   masterStartReq,
  input  wire logic                   masterReadCmd,
  input  wire logic                   slaveReadCmd,
  input  wire logic                   txFifoNotEmpty,
  input  wire logic                   masterTx,
  input  wire logic                   slaveTx,
  input  wire logic                   driveBit,
  input  wire logic                   ackPhase,
  input  wire iac_pkg::iac_ack_kind_t ackKind,
  output logic [15:0]                 dataLineHoldTime,
  output logic                        txAbortFlush,
  output logic                        irq
);

  logic [2:0]  sclSync_q;
  logic [2:0]  sdaSync_q;
  logic        sclF_q;
  logic        sdaF_q;
  logic        sclRise;
  logic        sdaMismatch;
  logic [iac_pkg::RX_LEVEL_W-1:0] rxFillLevel_q;
  logic [15:0] holdTime_q;
  logic [5:0]  ctrlConfig_q;
  logic [15:0] abortCause_q;
  logic [15:0] abortSet;
  logic        sbyteCause_q;
  logic        sbyteCond;
  logic [2:0]  irqStatus_q;
  logic [2:0]  irqEnable_q;
  logic [2:0]  irqSet;
  logic        awGot_q;
  logic        wGot_q;
  logic [31:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wrEn;
  logic        abortClrWr;
  logic        irqClrWr;

  function automatic logic isMapped(input logic [31:0] a);
    if (a == iac_pkg::RX_FILL_COUNT_ADDR) begin
      isMapped = 1'b1;
    end else if (a == iac_pkg::DATA_HOLD_ADDR || a == iac_pkg::ABORT_CAUSE_ADDR) begin
      isMapped = 1'b1;
    end else if (a == iac_pkg::CTRL_CONFIG_ADDR || a == iac_pkg::ABORT_CLEAR_ADDR) begin
      isMapped = 1'b1;
    end else if (a == iac_pkg::IRQ_STATUS_ADDR || a == iac_pkg::IRQ_ENABLE_ADDR) begin
      isMapped = 1'b1;
    end else begin
      isMapped = (a == iac_pkg::IRQ_CLEAR_ADDR);
    end
  endfunction : isMapped
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    mergeBytes = old;
  endfunction : mergeBytes

  // Pad resync; a change counts once stages two and three agree
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      sclF_q    <= 1'b1;
      sdaF_q    <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      if (sclSync_q[1] == sclSync_q[2]) begin
        sclF_q <= sclSync_q[2];
      end
      if (sdaSync_q[1] == sdaSync_q[2]) begin
        sdaF_q <= sdaSync_q[2];
      end
    end
  end

  assign sclRise     = (sclSync_q[1] == sclSync_q[2]) && sclSync_q[2] && !sclF_q;
  assign sdaMismatch = sclRise && (masterTx || slaveTx) && (sdaF_q != driveBit);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxFillLevel_q <= '0;
    end else if (rxPush && !rxPop && rxFillLevel_q < iac_pkg::RX_LEVEL_W'(RX_DEPTH)) begin
      rxFillLevel_q <= rxFillLevel_q + 1'b1;
    end else if (rxPop && !rxPush && rxFillLevel_q != '0) begin
      rxFillLevel_q <= rxFillLevel_q - 1'b1;
    end
  end

  assign wrEn       = awGot_q && wGot_q && !s_axi_bvalid;
  assign abortClrWr = wrEn && awAddr_q == iac_pkg::ABORT_CLEAR_ADDR;
  assign irqClrWr   = wrEn && awAddr_q == iac_pkg::IRQ_CLEAR_ADDR;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      holdTime_q   <= iac_pkg::DATA_HOLD_RESET;
      ctrlConfig_q <= iac_pkg::CTRL_CONFIG_RESET;
      irqEnable_q  <= iac_pkg::IRQ_RESET;
    end else if (wrEn) begin
      if (awAddr_q == iac_pkg::DATA_HOLD_ADDR) begin
        holdTime_q <= 16'(mergeBytes({16'h0000, holdTime_q}, wData_q, wStrb_q));
      end else if (awAddr_q == iac_pkg::CTRL_CONFIG_ADDR) begin
        ctrlConfig_q <= 6'(mergeBytes({26'h0, ctrlConfig_q}, wData_q, wStrb_q));
      end else if (awAddr_q == iac_pkg::IRQ_ENABLE_ADDR) begin
        irqEnable_q <= 3'(mergeBytes({29'h0, irqEnable_q}, wData_q, wStrb_q));
      end
    end
  end

  // start byte requested with restart disabled
  assign sbyteCond = !ctrlConfig_q[iac_pkg::CFG_RESTART_EN] && ctrlConfig_q[iac_pkg::CFG_SPECIAL]
                     && ctrlConfig_q[iac_pkg::CFG_GENERAL_CALL_OR_START_SELECT];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sbyteCause_q <= 1'b0;
    end else if (!sbyteCond) begin
      sbyteCause_q <= 1'b0;
    end else if (masterStartReq) begin
      sbyteCause_q <= 1'b1;
    end
  end

  // master and slave sources are separate terms, except bit 12 set by both
  always_comb begin
    abortSet = '0;
    abortSet[iac_pkg::AB_SLV_RD_CMD] = slaveReadReq && dataCmdWrite && dataCmdReadBit;
    // slave bus loss, with general flag
    abortSet[iac_pkg::AB_SLV_BUS_LOSS] = sdaMismatch && slaveTx;
    abortSet[iac_pkg::AB_ARBITRATION_LOSS_FLAG] = sdaMismatch;
    abortSet[iac_pkg::AB_SLV_FLUSH] = slaveReadCmd && txFifoNotEmpty;
    abortSet[iac_pkg::AB_MASTER_DIS] = masterStartReq && !ctrlConfig_q[iac_pkg::CFG_MASTER_EN];
    abortSet[iac_pkg::AB_TEN_BIT_RD] = masterStartReq && masterReadCmd
        && !ctrlConfig_q[iac_pkg::CFG_RESTART_EN] && ctrlConfig_q[iac_pkg::CFG_TEN_BIT];
    // re-asserts the cycle after a clear
    abortSet[iac_pkg::AB_SBYTE_NORST] = (masterStartReq && sbyteCond)
        || (sbyteCause_q && sbyteCond && !abortClrWr);
    abortSet[iac_pkg::AB_HS_NORST] = masterStartReq && !ctrlConfig_q[iac_pkg::CFG_RESTART_EN]
        && ctrlConfig_q[iac_pkg::CFG_HIGH_SPEED];
    abortSet[iac_pkg::AB_SBYTE_ACKED] = sclRise && ackPhase && !sdaF_q
        && ackKind == iac_pkg::ACK_START_BYTE;
    abortSet[iac_pkg::AB_HS_ACKED] = sclRise && ackPhase && !sdaF_q
        && ackKind == iac_pkg::ACK_HS_CODE && ctrlConfig_q[iac_pkg::CFG_HIGH_SPEED];
    abortSet[iac_pkg::AB_DATA_NACK] = sclRise && ackPhase && sdaF_q
        && ackKind == iac_pkg::ACK_DATA;
    abortSet[iac_pkg::AB_ADDR7_NACK] = sclRise && ackPhase && sdaF_q
        && ackKind == iac_pkg::ACK_ADDR7 && !ctrlConfig_q[iac_pkg::CFG_TEN_BIT];
  end

  // read-only flags; a set beats the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      abortCause_q <= iac_pkg::ABORT_CAUSE_RESET;
    end else if (abortClrWr) begin
      abortCause_q <= abortSet;
    end else begin
      abortCause_q <= abortCause_q | abortSet;
    end
  end

  // flush pulse toward the transmit FIFO
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txAbortFlush <= 1'b0;
    end else begin
      txAbortFlush <= abortSet[iac_pkg::AB_SLV_FLUSH];
    end
  end

  assign irqSet = {abortSet[iac_pkg::AB_ARBITRATION_LOSS_FLAG], abortSet[iac_pkg::AB_SLV_FLUSH], |abortSet};
  // Sticky interrupt status; set wins over write-one clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus_q <= iac_pkg::IRQ_RESET;
      irq         <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~(irqClrWr ? wData_q[2:0] : 3'h0)) | irqSet;
      irq         <= |(irqStatus_q & irqEnable_q);
    end
  end

  assign dataLineHoldTime = holdTime_q;
  // Write channel: address and data taken in either order
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      awGot_q       <= 1'b0;
      wGot_q        <= 1'b0;
      awAddr_q      <= 32'h0000_0000;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= iac_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awGot_q       <= 1'b1;
        awAddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wGot_q       <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        awGot_q      <= 1'b0;
        wGot_q       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr_q) ? iac_pkg::RESP_OKAY : iac_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel, answer one cycle after the address
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= iac_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isMapped(s_axi_araddr) ? iac_pkg::RESP_OKAY : iac_pkg::RESP_SLVERR;
      if (s_axi_araddr == iac_pkg::RX_FILL_COUNT_ADDR) begin
        s_axi_rdata <= {26'h0, rxFillLevel_q};
      end else if (s_axi_araddr == iac_pkg::DATA_HOLD_ADDR) begin
        s_axi_rdata <= {16'h0000, holdTime_q};
      end else if (s_axi_araddr == iac_pkg::ABORT_CAUSE_ADDR) begin
        s_axi_rdata <= {16'h0000, abortCause_q};
      end else if (s_axi_araddr == iac_pkg::CTRL_CONFIG_ADDR) begin
        s_axi_rdata <= {26'h0, ctrlConfig_q};
      end else if (s_axi_araddr == iac_pkg::IRQ_STATUS_ADDR) begin
        s_axi_rdata <= {29'h0, irqStatus_q};
      end else if (s_axi_araddr == iac_pkg::IRQ_ENABLE_ADDR) begin
        s_axi_rdata <= {29'h0, irqEnable_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_rxLevelUp;
    rxPush && !rxPop && rxFillLevel_q < 6'(RX_DEPTH)
      |=> rxFillLevel_q == $past(rxFillLevel_q) + 6'd1;
  endproperty
  a_rxLevelUp: assert property (p_rxLevelUp) else $error("rx level did not count push");
  property p_slvRdCmd;
    slaveReadReq && dataCmdWrite && dataCmdReadBit |=> abortCause_q[15];
  endproperty
  a_slvRdCmd: assert property (p_slvRdCmd) else $error("bit 15 not set");
  property p_slvLossPair;
    $rose(abortCause_q[14]) |-> abortCause_q[12];
  endproperty
  a_slvLossPair: assert property (p_slvLossPair) else $error("bit 14 without bit 12");
  property p_mismatch;
    sdaMismatch |=> abortCause_q[12] && irqStatus_q[2];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");
  property p_flush;
    slaveReadCmd && txFifoNotEmpty |=> abortCause_q[13] && txAbortFlush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush not raised");
  // A clear in the same cycle may drop bit 14; only a new set is wrong
  property p_masterArb;
    sdaMismatch && masterTx && !slaveTx
      |=> abortCause_q[12] && (!abortCause_q[14] || $past(abortCause_q[14]));
  endproperty
  a_masterArb: assert property (p_masterArb) else $error("master arb loss wrong");
  property p_masterDis;
    masterStartReq && !ctrlConfig_q[0] |=> abortCause_q[11];
  endproperty
  a_masterDis: assert property (p_masterDis) else $error("bit 11 not set");
  property p_tenBitRd;
    masterStartReq && masterReadCmd && ctrlConfig_q[2:1] == 2'b10 |=> abortCause_q[10];
  endproperty
  a_tenBitRd: assert property (p_tenBitRd) else $error("bit 10 not set");
  property p_sbyte;
    masterStartReq && sbyteCond |=> abortCause_q[9];
  endproperty
  a_sbyte: assert property (p_sbyte) else $error("bit 9 not set");
  property p_sbyteAgain;
    abortClrWr && sbyteCause_q && sbyteCond && !masterStartReq ##1 sbyteCond
      |-> !abortCause_q[9] ##1 abortCause_q[9];
  endproperty
  a_sbyteAgain: assert property (p_sbyteAgain) else $error("bit 9 did not re-assert");
  property p_hsNoRestart;
    masterStartReq && ctrlConfig_q[3] && !ctrlConfig_q[1] |=> abortCause_q[8];
  endproperty
  a_hsNoRestart: assert property (p_hsNoRestart) else $error("bit 8 not set");
  property p_sbyteAck;
    sclRise && ackPhase && !sdaF_q && ackKind == iac_pkg::ACK_START_BYTE |=> abortCause_q[7];
  endproperty
  a_sbyteAck: assert property (p_sbyteAck) else $error("bit 7 not set");
  property p_hsAck;
    abortSet[6] |-> !sdaF_q && ackKind == iac_pkg::ACK_HS_CODE ##1 abortCause_q[6];
  endproperty
  a_hsAck: assert property (p_hsAck) else $error("bit 6 wrong");
  property p_dataNack;
    sclRise && ackPhase && sdaF_q && ackKind == iac_pkg::ACK_DATA |=> abortCause_q[3];
  endproperty
  a_dataNack: assert property (p_dataNack) else $error("bit 3 not set");
  property p_addrNack;
    abortSet[0] |-> sdaF_q && !ctrlConfig_q[2] ##1 abortCause_q[0];
  endproperty
  a_addrNack: assert property (p_addrNack) else $error("bit 0 wrong");
  property p_stickyFlags;
    !abortClrWr |=> (abortCause_q & $past(abortCause_q)) == $past(abortCause_q);
  endproperty
  a_stickyFlags: assert property (p_stickyFlags) else $error("abort flag fell");
  property p_holdWrite;
    wrEn && awAddr_q == iac_pkg::DATA_HOLD_ADDR && wStrb_q == 4'hF
      |=> dataLineHoldTime == $past(wData_q[15:0]);
  endproperty
  a_holdWrite: assert property (p_holdWrite) else $error("hold time not written");

endmodule : iac_status_top

//--- hdl/iac_pkg.sv
/*
  Constants for the abort-cause, receive-level and data-hold status block:
  register byte addresses, field positions, reset values and the enum used
  at the block's ports.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package iac_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  localparam logic [31:0] RX_FILL_COUNT_ADDR = 32'h5000_1478;
  localparam logic [31:0] DATA_HOLD_ADDR     = 32'h5000_147C;
  localparam logic [31:0] ABORT_CAUSE_ADDR   = 32'h5000_1480;
  localparam logic [31:0] CTRL_CONFIG_ADDR   = 32'h5000_14A0;
  localparam logic [31:0] ABORT_CLEAR_ADDR   = 32'h5000_14A4;
  localparam logic [31:0] IRQ_STATUS_ADDR    = 32'h5000_14A8;
  localparam logic [31:0] IRQ_ENABLE_ADDR    = 32'h5000_14AC;
  localparam logic [31:0] IRQ_CLEAR_ADDR     = 32'h5000_14B0;

  localparam logic [15:0] DATA_HOLD_RESET   = 16'h0001;
  localparam logic [15:0] ABORT_CAUSE_RESET = 16'h0000;
  localparam logic [5:0]  CTRL_CONFIG_RESET = 6'h03;
  localparam logic [2:0]  IRQ_RESET         = 3'h0;
  localparam int unsigned RX_LEVEL_W        = 6;

  // Control configuration bit positions
  localparam int unsigned CFG_MASTER_EN  = 0;
  localparam int unsigned CFG_RESTART_EN = 1;
  localparam int unsigned CFG_TEN_BIT    = 2;
  localparam int unsigned CFG_HIGH_SPEED = 3;
  localparam int unsigned CFG_SPECIAL    = 4;
  localparam int unsigned CFG_GENERAL_CALL_OR_START_SELECT = 5;

  // Abort cause bit positions
  localparam int unsigned AB_SLV_RD_CMD    = 15;
  localparam int unsigned AB_SLV_BUS_LOSS  = 14;
  localparam int unsigned AB_SLV_FLUSH     = 13;
  localparam int unsigned AB_ARBITRATION_LOSS_FLAG      = 12;
  localparam int unsigned AB_MASTER_DIS    = 11;
  localparam int unsigned AB_TEN_BIT_RD    = 10;
  localparam int unsigned AB_SBYTE_NORST   = 9;
  localparam int unsigned AB_HS_NORST      = 8;
  localparam int unsigned AB_SBYTE_ACKED   = 7;
  localparam int unsigned AB_HS_ACKED      = 6;
  localparam int unsigned AB_DATA_NACK     = 3;
  localparam int unsigned AB_ADDR7_NACK    = 0;

  // Interrupt bit positions
  localparam int unsigned IRQ_ABORT = 0;
  localparam int unsigned IRQ_FLUSH = 1;
  localparam int unsigned IRQ_ARB   = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Which byte the master is waiting to see acknowledged
  typedef enum logic [1:0] {
    ACK_START_BYTE,
    ACK_HS_CODE,
    ACK_ADDR7,
    ACK_DATA
  } iac_ack_kind_t;

endpackage : iac_pkg

//--- verification/iac_bus_peer.sv
/*
  Remote two-wire party: drives the clock and data lines one bit cell at a time.
  Assumes open-drain lines with pull-ups, so both idle high between frames.
*/
module iac_bus_peer (
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // One 240 ns bit cell; data released to the pull-up before idle
  task automatic send_bit(input logic level);
    scl = 1'b0;
    #40 sda = level;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40 sda = 1'b1;
    #40 scl = 1'b1;
  endtask : send_bit

endmodule : iac_bus_peer

//--- verification/test_i2c_abort_cause_and_levels.sv
/*
  Bench for the abort-cause status block: registers, receive level, abort causes
  from events and from the bus lines, interrupt.
  Assumes the design package and the bus peer model are compiled first.
*/
module test_i2c_abort_cause_and_levels;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, rxPush, rxPop, slaveReadReq, dataCmdWrite, dataCmdReadBit;
  logic        masterStartReq, masterReadCmd, slaveReadCmd, txFifoNotEmpty, masterTx;
  logic        slaveTx, driveBit, ackPhase, txAbortFlush, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] dataLineHoldTime;
  wire         sclIn, sdaIn;
  int          n_errors, total_checks;
  iac_pkg::iac_ack_kind_t ackKind;

  iac_status_top #(.RX_DEPTH(4)) i_dut (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn, .sdaIn, .rxPush,
    .rxPop, .slaveReadReq, .dataCmdWrite, .dataCmdReadBit, .masterStartReq, .masterReadCmd,
    .slaveReadCmd, .txFifoNotEmpty, .masterTx, .slaveTx, .driveBit, .ackPhase, .ackKind,
    .dataLineHoldTime, .txAbortFlush, .irq);
  iac_bus_peer peer (.scl(sclIn), .sda(sdaIn));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ready lines stay high, so no response is ever stalled
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d   = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd

  task automatic clr();
    wr(iac_pkg::ABORT_CLEAR_ADDR, 32'h0000_0000);
  endtask : clr

  task automatic ev(input int k);
    @(posedge mclk);
    case (k)
      15: {slaveReadReq, dataCmdWrite, dataCmdReadBit} <= 3'h7;
      13: {slaveReadCmd, txFifoNotEmpty} <= 2'h3;
      default: {masterStartReq, masterReadCmd} <= {1'b1, k == 10};
    endcase
    @(posedge mclk);
    {slaveReadReq, dataCmdWrite, dataCmdReadBit, slaveReadCmd, txFifoNotEmpty} <= 5'h00;
    {masterStartReq, masterReadCmd} <= 2'h0;
    // Flush pulse is launched at the edge above; look one edge later
    @(posedge mclk);
    chk(txAbortFlush, k == 13);
  endtask : ev

  task automatic t_regs();
    rd(iac_pkg::RX_FILL_COUNT_ADDR);
    chk(d, 32'h0000_0000);
    rd(iac_pkg::DATA_HOLD_ADDR);
    chk(d, 32'h0000_0001);
    wr(iac_pkg::DATA_HOLD_ADDR, 32'hFFFF_ABCD);
    rd(iac_pkg::DATA_HOLD_ADDR);
    chk(d, 32'h0000_ABCD);
    chk(dataLineHoldTime, 32'h0000_ABCD);
    wr(iac_pkg::ABORT_CAUSE_ADDR, 32'h0000_FFFF);
    rd(iac_pkg::ABORT_CAUSE_ADDR);
    chk(d, 32'h0000_0000);
    wr(32'h5000_14FC, 32'h0000_0001);
    chk(rsp, iac_pkg::RESP_SLVERR);
    rd(32'h5000_14FC);
    chk(rsp, iac_pkg::RESP_SLVERR);
  endtask : t_regs

  // Depth 4: five pushes saturate, five pops stop at empty
  task automatic t_rx();
    rxPush <= 1'b1;
    repeat (5) @(posedge mclk);
    rxPush <= 1'b0;
    rd(iac_pkg::RX_FILL_COUNT_ADDR);
    chk(d, 32'h0000_0004);
    rxPop <= 1'b1;
    repeat (5) @(posedge mclk);
    rxPop <= 1'b0;
    rd(iac_pkg::RX_FILL_COUNT_ADDR);
    chk(d, 32'h0000_0000);
  endtask : t_rx

  task automatic t_events();
    int ks[6] = '{15, 13, 11, 10, 8, 9};
    logic [5:0] cf[6] = '{6'h03, 6'h03, 6'h02, 6'h05, 6'h09, 6'h31};
    for (int i = 0; i < 6; i++) begin
      wr(iac_pkg::CTRL_CONFIG_ADDR, {26'h0, cf[i]});
      ev(ks[i]);
      rd(iac_pkg::ABORT_CAUSE_ADDR);
      chk(d, 32'h0000_0001 << ks[i]);
      clr();
    end
    rd(iac_pkg::ABORT_CAUSE_ADDR);
    chk(d, 32'h0000_0200);
    wr(iac_pkg::CTRL_CONFIG_ADDR, 32'h0000_0033);
    clr();
    rd(iac_pkg::ABORT_CAUSE_ADDR);
    chk(d, 32'h0000_0000);
    chk(irq, 1'b0);
    wr(iac_pkg::IRQ_ENABLE_ADDR, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b1);
    wr(iac_pkg::IRQ_CLEAR_ADDR, 32'h0000_0007);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    rd(iac_pkg::IRQ_CLEAR_ADDR);
    chk(d, 32'h0000_0000);
  endtask : t_events

  task automatic t_wire();
    slaveTx  <= 1'b1;
    driveBit <= 1'b1;
    peer.send_bit(1'b0);
    @(posedge mclk);
    slaveTx  <= 1'b0;
    masterTx <= 1'b1;
    rd(iac_pkg::ABORT_CAUSE_ADDR);
    chk(d, 32'h0000_5000);
    clr();
    fork
      peer.send_bit(1'b0);
      ev(13);
    join
    @(posedge mclk);
    masterTx <= 1'b0;
    rd(iac_pkg::ABORT_CAUSE_ADDR);
    chk(d, 32'h0000_3000);
    clr();
  endtask : t_wire

  task automatic t_ack();
    int bits[4] = '{7, 6, 0, 3};
    wr(iac_pkg::CTRL_CONFIG_ADDR, 32'h0000_000B);
    for (int i = 0; i < 4; i++) begin
      ackKind  <= iac_pkg::iac_ack_kind_t'(i);
      ackPhase <= 1'b1;
      peer.send_bit(i > 1);
      @(posedge mclk);
      ackPhase <= 1'b0;
      rd(iac_pkg::ABORT_CAUSE_ADDR);
      chk(d, 32'h0000_0001 << bits[i]);
      clr();
    end
  endtask : t_ack

  task automatic wrap_up();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #100_000;
    n_errors++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rxPush, rxPop, slaveReadReq} = '0;
    {dataCmdWrite, dataCmdReadBit, masterStartReq, masterReadCmd, slaveReadCmd} = '0;
    {txFifoNotEmpty, masterTx, slaveTx, driveBit, ackPhase} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_wstrb = 4'hF;
    ackKind = iac_pkg::ACK_START_BYTE;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_rx();
    t_events();
    t_wire();
    t_ack();
    wrap_up();
  end

endmodule : test_i2c_abort_cause_and_levels
